// *** src/cprf_core_regs.sv ***
/*
  Internal register set of the 8-bit core: accumulator, index, program
  counter, stack pointer and flags, with the register-space decode that
  exposes the flags and routes all other accesses to the selected bank.
  Assumes the instruction sequencer runs on the same clock and issues
  single-cycle commands; peripheral registers answer reads in the same cycle.
*/
module cprf_core_regs (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Accumulator and index commands.
  input wire logic i_acc_load,
  input wire logic [7:0] i_acc_data,
  input wire logic i_idx_load,
  input wire logic [7:0] i_idx_data,
  input wire logic i_swap_acc_idx,
  // Program counter commands.
  input wire logic i_pc_inc,
  input wire logic i_pc_load,
  input wire logic [15:0] i_pc_data,
  // Stack pointer commands.
  input wire cprf_pkg::cprf_sp_op_t i_sp_op,
  input wire logic [7:0] i_sp_operand,
  // Flag commands.
  input wire cprf_pkg::cprf_flag_op_t i_flag_op,
  input wire logic [7:0] i_flag_operand,
  input wire logic i_alu_carry,
  input wire logic i_alu_zero,
  // Register-space access from the sequencer.
  input wire cprf_pkg::cprf_reg_req_t i_reg_req,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rvalid,
  // Register-space access toward the peripheral registers.
  output cprf_pkg::cprf_periph_req_t o_periph_req,
  input wire logic [7:0] i_periph_rdata,
  // Interrupt gate.
  input wire logic i_irq_pending,
  input wire logic i_insn_boundary,
  output logic o_irq_accept,
  // Register state seen by the datapath.
  output logic [7:0] o_acc,
  output logic [7:0] o_idx,
  output logic [15:0] o_pc,
  output logic o_pc_page_cross,
  output logic [7:0] o_sp,
  output logic [7:0] o_stack_addr,
  output cprf_pkg::cprf_flags_t o_flags
);

  // True when an offset selects the flag register; the bank is not looked at.
  function automatic logic is_flags_offset(input logic [7:0] addr);
    is_flags_offset = (addr == cprf_pkg::CPRF_FLAGS_OFFSET);
  endfunction

  // Next program counter value for a sequential step. It is formed one bit
  // wider so the carry out of the count is visible; callers drop the top bit
  // on purpose, which makes the counter wrap at sixteen bits.
  function automatic logic [16:0] pc_step(input logic [15:0] pc_now);
    pc_step = {1'b0, pc_now} + 17'h0_0001;
  endfunction

  // Registered state and the next values computed for it.
  logic [7:0] acc;
  logic [7:0] next_acc;
  logic [7:0] idx;
  logic [7:0] next_idx;
  logic [15:0] pc;
  logic [15:0] next_pc;
  logic page_cross;
  logic next_page_cross;
  logic [7:0] rdata;
  logic [7:0] next_rdata;
  logic rvalid;
  logic next_rvalid;
  logic [16:0] pc_inc_val;
  logic flags_hit;
  cprf_pkg::cprf_flags_t flags;

  // Stack pointer with stepping and wrap.
  cprf_stack_ptr u_stack_ptr (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_op(i_sp_op),
    .i_operand(i_sp_operand),
    .o_sp(o_sp),
    .o_stack_addr(o_stack_addr)
  );

  // Flag register with logical immediate operations.
  cprf_flag_reg u_flag_reg (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_op(i_flag_op),
    .i_operand(i_flag_operand),
    .i_alu_carry(i_alu_carry),
    .i_alu_zero(i_alu_zero),
    .o_flags(flags)
  );

  // Accumulator and index are reached only through these commands, never by
  // an offset. A swap has priority over the individual loads.
  always_comb begin
    next_acc = acc;
    next_idx = idx;
    if (i_swap_acc_idx) begin
      next_acc = idx;
      next_idx = acc;
    end else begin
      if (i_acc_load) begin
        next_acc = i_acc_data;
      end
      if (i_idx_load) begin
        next_idx = i_idx_data;
      end
    end
  end

  // Accumulator and index registers.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      acc <= cprf_pkg::CPRF_ACC_RESET;
      idx <= cprf_pkg::CPRF_IDX_RESET;
    end else begin
      acc <= next_acc;
      idx <= next_idx;
    end
  end

  // A load wins over an increment. The page-cross flag tells the sequencer
  // that an increment moved the upper byte, which costs the core an extra cycle.
  always_comb begin
    pc_inc_val = pc_step(pc);
    next_pc = pc;
    next_page_cross = 1'b0;
    if (i_pc_load) begin
      next_pc = i_pc_data;
    end else if (i_pc_inc) begin
      next_pc = pc_inc_val[15:0];
      next_page_cross = (pc_inc_val[15:8] != pc[15:8]);
    end
  end

  // Program counter register.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pc <= cprf_pkg::CPRF_PC_RESET;
      page_cross <= 1'b0;
    end else begin
      pc <= next_pc;
      page_cross <= next_page_cross;
    end
  end

  // Register-space decode. The flag offset is claimed in both banks; every
  // other offset goes out with the bank bit taken from the flags, giving a
  // 2 x 256 byte space. A write to the flag offset is dropped on purpose:
  // the flags change only through the flag commands.
  assign flags_hit = is_flags_offset(i_reg_req.addr);

  always_comb begin
    o_periph_req.rd = i_reg_req.rd & ~flags_hit;
    o_periph_req.wr = i_reg_req.wr & ~is_flags_offset(i_reg_req.addr);
    o_periph_req.bank = flags.register_bank_select;
    o_periph_req.addr = i_reg_req.addr;
    o_periph_req.wdata = i_reg_req.wdata;
  end

  // Read data is registered and shown one cycle after the request.
  always_comb begin
    next_rvalid = i_reg_req.rd;
    next_rdata = rdata;
    if (i_reg_req.rd) begin
      if (flags_hit) begin
        next_rdata = flags;
      end else begin
        next_rdata = i_periph_rdata;
      end
    end
  end

  // Read data register.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata <= 8'h00;
      rvalid <= 1'b0;
    end else begin
      rdata <= next_rdata;
      rvalid <= next_rvalid;
    end
  end

  // Interrupts are taken only at an instruction boundary and only while
  // the global enable is set; the handshake output is combinational.
  // A request that arrives while the enable is clear is not lost here: it
  // simply waits in the controller until the sequencer sets the enable.
  assign o_irq_accept = i_irq_pending & i_insn_boundary
    & flags.global_interrupt_enable;

  // State outputs. Each comes straight from a flip-flop, so the datapath
  // never sees a value that is still settling within the cycle.
  assign o_acc = acc;
  assign o_idx = idx;
  assign o_pc = pc;
  assign o_pc_page_cross = page_cross;
  assign o_flags = flags;
  assign o_reg_rdata = rdata;
  assign o_reg_rvalid = rvalid;

endmodule // cprf_core_regs

// *** pkg/cprf_pkg.sv ***
/*
  Shared constants, field layout and command encodings for the core's
  internal register set: accumulator, index, program counter, stack
  pointer and flags.
  Assumes one core clock and one asynchronous active-low reset.
*/
package cprf_pkg;

  // Widths of the internal registers and of the register address space.
  localparam int unsigned CPRF_DATA_W = 8;
  localparam int unsigned CPRF_PC_W = 16;
  localparam int unsigned CPRF_ADDR_W = 8;

  // The only internal register with a location in the register space.
  localparam logic [7:0] CPRF_FLAGS_OFFSET = 8'hF7;

  // Reset values.
  localparam logic [7:0] CPRF_ACC_RESET = 8'h00;
  localparam logic [7:0] CPRF_IDX_RESET = 8'h00;
  localparam logic [15:0] CPRF_PC_RESET = 16'h0000;
  localparam logic [7:0] CPRF_SP_RESET = 8'h00;
  localparam logic [7:0] CPRF_FLAGS_RESET = 8'h02;

  // Flag field positions.
  localparam int unsigned CPRF_FLAG_RAM_PAGE_MODE_FIELD_LSB = 6;
  localparam int unsigned CPRF_FLAG_BANK_BIT = 4;
  localparam int unsigned CPRF_FLAG_CARRY_BIT = 2;
  localparam int unsigned CPRF_FLAG_ZERO_BIT = 1;
  localparam int unsigned CPRF_FLAG_GIE_BIT = 0;

  // Bits 5 and 3 are reserved and always hold zero.
  localparam logic [7:0] CPRF_FLAGS_USED_MASK = 8'hD7;

  // Flag register layout.
  typedef struct packed {
    logic [1:0] ram_page_mode_field;
    logic rsvd5;
    logic register_bank_select;
    logic rsvd3;
    logic carry;
    logic zero;
    logic global_interrupt_enable;
  } cprf_flags_t;

  // Stack pointer operations.
  typedef enum logic [2:0] {
    CPRF_SP_NONE = 3'b000,
    CPRF_SP_PUSH = 3'b001,
    CPRF_SP_POP = 3'b010,
    CPRF_SP_ADD = 3'b011,
    CPRF_SP_LOAD = 3'b100
  } cprf_sp_op_t;

  // Flag register operations.
  typedef enum logic [2:0] {
    CPRF_FLAG_NONE = 3'b000,
    CPRF_FLAG_AND = 3'b001,
    CPRF_FLAG_OR = 3'b010,
    CPRF_FLAG_XOR = 3'b011,
    CPRF_FLAG_LOAD = 3'b100,
    CPRF_FLAG_ALU = 3'b101
  } cprf_flag_op_t;

  // Register-space access from the instruction sequencer.
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cprf_reg_req_t;

  // Register-space access forwarded to the peripheral registers.
  typedef struct packed {
    logic rd;
    logic wr;
    logic bank;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cprf_periph_req_t;

endpackage

// *** src/cprf_stack_ptr.sv ***
/*
  Stack pointer of the core: steps on push and pop, wraps modulo 256.
  Assumes at most one operation per cycle from the instruction sequencer.
*/
module cprf_stack_ptr (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Operation.
  input wire cprf_pkg::cprf_sp_op_t i_op,
  input wire logic [7:0] i_operand,
  // State.
  output logic [7:0] o_sp,
  output logic [7:0] o_stack_addr
);

  logic [7:0] sp;
  logic [7:0] next_sp;

  // Push post-increments, pop pre-decrements; 8-bit arithmetic gives the wrap.
  always_comb begin
    next_sp = sp;
    case (i_op)
      cprf_pkg::CPRF_SP_PUSH: next_sp = sp + 8'h01;
      cprf_pkg::CPRF_SP_POP: next_sp = sp - 8'h01;
      cprf_pkg::CPRF_SP_ADD: next_sp = sp + i_operand;
      cprf_pkg::CPRF_SP_LOAD: next_sp = i_operand;
      default: next_sp = sp;
    endcase
  end

  // State register.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sp <= cprf_pkg::CPRF_SP_RESET;
    end else begin
      sp <= next_sp;
    end
  end

  // A pop reads the byte below the pointer; anything else addresses the pointer.
  assign o_stack_addr = (i_op == cprf_pkg::CPRF_SP_POP) ? sp - 8'h01 : sp;
  assign o_sp = sp;

endmodule // cprf_stack_ptr

// *** src/cprf_flag_reg.sv ***
/*
  Flag register of the core with logical immediate operations.
  Assumes the sequencer issues at most one flag operation per cycle.
*/
module cprf_flag_reg (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Operation.
  input wire cprf_pkg::cprf_flag_op_t i_op,
  input wire logic [7:0] i_operand,
  input wire logic i_alu_carry,
  input wire logic i_alu_zero,
  // State.
  output cprf_pkg::cprf_flags_t o_flags
);

  logic [7:0] flags;
  logic [7:0] next_flags;
  logic [7:0] raw;

  // Reserved bits are forced to zero so that a careless mask cannot set them.
  always_comb begin
    raw = flags;
    case (i_op)
      cprf_pkg::CPRF_FLAG_AND: raw = flags & i_operand;
      cprf_pkg::CPRF_FLAG_OR: raw = flags | i_operand;
      cprf_pkg::CPRF_FLAG_XOR: raw = flags ^ i_operand;
      cprf_pkg::CPRF_FLAG_LOAD: raw = i_operand;
      cprf_pkg::CPRF_FLAG_ALU: begin
        raw[cprf_pkg::CPRF_FLAG_CARRY_BIT] = i_alu_carry;
        raw[cprf_pkg::CPRF_FLAG_ZERO_BIT] = i_alu_zero;
      end
      default: raw = flags;
    endcase
    next_flags = raw & cprf_pkg::CPRF_FLAGS_USED_MASK;
  end

  // State register.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flags <= cprf_pkg::CPRF_FLAGS_RESET;
    end else begin
      flags <= next_flags;
    end
  end

  assign o_flags = cprf_pkg::cprf_flags_t'(flags);

endmodule // cprf_flag_reg

// *** verif/cprf_props.sv ***
/*
  Port checks for the core register set.
  Assumes one core clock and the active-low reset of the top module.
*/
module cprf_props (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Commands and requests.
  input wire cprf_pkg::cprf_sp_op_t i_sp_op,
  input wire cprf_pkg::cprf_flag_op_t i_flag_op,
  input wire logic [7:0] i_flag_operand,
  input wire logic i_pc_inc,
  input wire logic i_pc_load,
  input wire cprf_pkg::cprf_reg_req_t i_reg_req,
  input wire logic i_irq_pending,
  input wire logic i_insn_boundary,
  // Outputs.
  input wire logic [7:0] o_reg_rdata,
  input wire logic o_reg_rvalid,
  input wire cprf_pkg::cprf_periph_req_t o_periph_req,
  input wire logic o_irq_accept,
  input wire logic [15:0] o_pc,
  input wire logic [7:0] o_sp,
  input wire cprf_pkg::cprf_flags_t o_flags
);
  timeunit 1ns;
  timeprecision 100ps;

  // One domain, so the clock and reset are stated once.
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  // Every read is answered exactly one cycle later, flags read as they stood.
  property p_rvalid; i_reg_req.rd |=> o_reg_rvalid; endproperty
  a_rvalid: assert property (p_rvalid) else $error("read not answered");
  property p_frd; i_reg_req.rd && i_reg_req.addr == 8'hF7 |=> o_reg_rdata == $past(o_flags);
  endproperty
  a_frd: assert property (p_frd) else $error("flag read wrong");
  // The flag offset is never passed on to the peripherals.
  property p_mask; i_reg_req.addr == 8'hF7 |-> !o_periph_req.rd && !o_periph_req.wr; endproperty
  a_mask: assert property (p_mask) else $error("flag access forwarded");
  property p_bank; o_periph_req.bank == o_flags.register_bank_select; endproperty
  a_bank: assert property (p_bank) else $error("bank steer wrong");
  // Stack steps wrap modulo 256 by the 8-bit cast.
  property p_push; i_sp_op == cprf_pkg::CPRF_SP_PUSH |=> o_sp == 8'($past(o_sp) + 8'h01);
  endproperty
  a_push: assert property (p_push) else $error("push step wrong");
  property p_pop; i_sp_op == cprf_pkg::CPRF_SP_POP |=> o_sp == 8'($past(o_sp) - 8'h01);
  endproperty
  a_pop: assert property (p_pop) else $error("pop step wrong");
  property p_and; i_flag_op == cprf_pkg::CPRF_FLAG_AND |=>
    o_flags == ($past(o_flags) & $past(i_flag_operand) & 8'hD7); endproperty
  a_and: assert property (p_and) else $error("flag and wrong");
  property p_pc; i_pc_inc && !i_pc_load |=> o_pc == 16'($past(o_pc) + 16'h0001); endproperty
  a_pc: assert property (p_pc) else $error("pc step wrong");
  property p_gie;
    o_irq_accept == (i_irq_pending && i_insn_boundary && o_flags.global_interrupt_enable);
  endproperty
  a_gie: assert property (p_gie) else $error("interrupt gate wrong");
endmodule // cprf_props

// *** verif/testbench.sv ***
/*
  Self-checking bench for the core register set.
  Assumes the top module drives nothing back into the bench but its outputs.
*/
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_clk, i_rst_n, i_acc_load, i_idx_load, i_swap_acc_idx, i_pc_inc, i_pc_load;
  logic i_alu_carry, i_alu_zero, i_irq_pending, i_insn_boundary;
  logic [7:0] i_acc_data, i_idx_data, i_sp_operand, i_flag_operand, i_periph_rdata;
  logic [15:0] i_pc_data, o_pc;
  cprf_pkg::cprf_sp_op_t i_sp_op;
  cprf_pkg::cprf_flag_op_t i_flag_op;
  cprf_pkg::cprf_reg_req_t i_reg_req;
  logic [7:0] o_reg_rdata, o_acc, o_idx, o_sp, o_stack_addr;
  logic o_reg_rvalid, o_irq_accept, o_pc_page_cross;
  cprf_pkg::cprf_periph_req_t o_periph_req;
  cprf_pkg::cprf_flags_t o_flags;
  int fails = 0;
  int check_count = 0;
  int cyc = 0;

  cprf_core_regs cprf_core_regs_i (.i_clk, .i_rst_n, .i_acc_load, .i_acc_data, .i_idx_load,
    .i_idx_data, .i_swap_acc_idx, .i_pc_inc, .i_pc_load, .i_pc_data, .i_sp_op, .i_sp_operand,
    .i_flag_op, .i_flag_operand, .i_alu_carry, .i_alu_zero, .i_reg_req, .o_reg_rdata,
    .o_reg_rvalid, .o_periph_req, .i_periph_rdata, .i_irq_pending, .i_insn_boundary,
    .o_irq_accept, .o_acc, .o_idx, .o_pc, .o_pc_page_cross, .o_sp, .o_stack_addr, .o_flags);

  // Free-running core clock, 4 ns period.
  initial begin
    i_clk = 0;
    forever #2 i_clk = ~i_clk;
  end

  // Compares one value and counts it.
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Lets the pending command be taken, then returns every command to rest.
  task automatic idle;
    @(posedge i_clk);
    {i_acc_load, i_idx_load, i_swap_acc_idx, i_pc_inc, i_pc_load} <= '0;
    i_sp_op <= cprf_pkg::CPRF_SP_NONE;
    i_flag_op <= cprf_pkg::CPRF_FLAG_NONE;
    #1;
  endtask

  task automatic fop(input cprf_pkg::cprf_flag_op_t op, input logic [7:0] v, e);
    @(posedge i_clk) begin
      i_flag_op <= op;
      i_flag_operand <= v;
    end
    idle;
    chk(o_flags, e);
  endtask

  // One-cycle register read; pr and b are the expected forward and bank.
  task automatic rreg(input logic [7:0] a, input logic pr, b, input logic [7:0] e);
    @(posedge i_clk) i_reg_req <= '{1'h1, 1'h0, a, 8'h00};
    #1 chk(o_periph_req.rd, pr);
    chk(o_periph_req.bank, b);
    @(posedge i_clk) i_reg_req <= '0;
    #1 chk(o_reg_rvalid, 1'h1);
    chk(o_reg_rdata, e);
  endtask

  task automatic wreg(input logic [7:0] a, d);
    @(posedge i_clk) i_reg_req <= '{1'h0, 1'h1, a, d};
    #1 chk(o_periph_req.wr, a != 8'hF7);
    chk(o_periph_req.addr, a);
    chk(o_periph_req.wdata, d);
    @(posedge i_clk) i_reg_req <= '0;
  endtask

  // Ends the run with the counts and the verdict.
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // A hang is cut short well beyond the few dozen cycles the tests need.
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 2000) begin
      fails++;
      conclude;
    end
  end

  // Main sequence.
  initial begin
    {i_rst_n, i_acc_load, i_idx_load, i_swap_acc_idx, i_pc_inc, i_pc_load} = '0;
    {i_acc_data, i_idx_data, i_sp_operand, i_flag_operand, i_pc_data} = '0;
    {i_alu_carry, i_alu_zero, i_irq_pending, i_insn_boundary} = 4'h f;
    i_periph_rdata = 8'hA5;
    i_sp_op = cprf_pkg::CPRF_SP_NONE;
    i_flag_op = cprf_pkg::CPRF_FLAG_NONE;
    i_reg_req = '0;
    repeat (10) @(posedge i_clk);
    i_rst_n <= 1'h1;
    #1 chk(o_acc, 8'h00);
    chk(o_idx, 8'h00);
    chk(o_pc, 16'h0000);
    chk(o_sp, 8'h00);
    chk(o_flags, 8'h02);
    chk(o_irq_accept, 1'h0);
    rreg(8'hF7, 1'h0, 1'h0, 8'h02);
    $display("reset test done");
    fop(cprf_pkg::CPRF_FLAG_OR, 8'h10, 8'h12);
    rreg(8'hF7, 1'h0, 1'h1, 8'h12);
    rreg(8'h10, 1'h1, 1'h1, 8'hA5);
    wreg(8'hF7, 8'hD7);
    rreg(8'hF7, 1'h0, 1'h1, 8'h12);
    fop(cprf_pkg::CPRF_FLAG_AND, 8'hEF, 8'h02);
    wreg(8'h20, 8'h3C);
    $display("bank test done");
    fop(cprf_pkg::CPRF_FLAG_XOR, 8'h03, 8'h01);
    chk(o_irq_accept, 1'h1);
    fop(cprf_pkg::CPRF_FLAG_OR, 8'hD7, 8'hD7);
    fop(cprf_pkg::CPRF_FLAG_LOAD, 8'h00, 8'h00);
    chk(o_irq_accept, 1'h0);
    fop(cprf_pkg::CPRF_FLAG_ALU, 8'h00, 8'h06);
    $display("flag test done");
    @(posedge i_clk) begin
      i_sp_op <= cprf_pkg::CPRF_SP_LOAD;
      i_sp_operand <= 8'hFF;
    end
    idle;
    @(posedge i_clk) i_sp_op <= cprf_pkg::CPRF_SP_PUSH;
    #1 chk(o_stack_addr, 8'hFF);
    idle;
    chk(o_sp, 8'h00);
    @(posedge i_clk) i_sp_op <= cprf_pkg::CPRF_SP_POP;
    #1 chk(o_stack_addr, 8'hFF);
    idle;
    chk(o_sp, 8'hFF);
    $display("stack test done");
    @(posedge i_clk) begin
      {i_pc_load, i_acc_load, i_idx_load} <= 3'h7;
      i_pc_data <= 16'h00FF;
      i_acc_data <= 8'h5A;
      i_idx_data <= 8'hC3;
    end
    idle;
    @(posedge i_clk) {i_pc_inc, i_swap_acc_idx} <= 2'h3;
    idle;
    chk(o_pc, 16'h0100);
    chk(o_pc_page_cross, 1'h1);
    chk(o_acc, 8'hC3);
    chk(o_idx, 8'h5A);
    $display("register test done");
    conclude;
  end
endmodule // testbench

// Checker beside the top module, watching its ports only.
bind cprf_core_regs cprf_props cprf_props_i (.i_clk, .i_rst_n, .i_sp_op, .i_flag_op,
  .i_flag_operand, .i_pc_inc, .i_pc_load, .i_reg_req, .i_irq_pending, .i_insn_boundary,
  .o_reg_rdata, .o_reg_rvalid, .o_periph_req, .o_irq_accept, .o_pc, .o_sp, .o_flags);
